// File: core/wdog_pkg.sv
`default_nettype none
package wdog_pkg;
  // register byte offsets on the apb port
  localparam logic [7:0] OFF_CONTROL      = 8'h00;
  localparam logic [7:0] OFF_RELOAD_UPPER = 8'h04;
  localparam logic [7:0] OFF_RELOAD_HIGH  = 8'h08;
  localparam logic [7:0] OFF_RELOAD_LOW   = 8'h0C;
  localparam logic [7:0] OFF_RESET_CAUSE  = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK     = 8'h18;
  localparam logic [7:0] OFF_COUNT        = 8'h1C;
  localparam logic [7:0] OFF_REFRESH      = 8'h20;

  // control field positions
  localparam int CTL_ENABLE_BIT   = 0;
  localparam int CTL_RST_EN_BIT   = 1;
  // reset-cause field positions
  localparam int CAUSE_WDOG_BIT   = 0;
  localparam int CAUSE_STOP_BIT   = 1;
  // interrupt field positions
  localparam int IRQ_TIMEOUT_BIT  = 0;
  localparam int IRQ_BADSEQ_BIT   = 1;

  // unlock code bytes
  localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

  // values after reset
  localparam logic [1:0]  CONTROL_RESET = 2'h0;
  localparam logic [23:0] RELOAD_RESET  = 24'h00_FFFF;
  localparam logic [1:0]  CAUSE_RESET   = 2'h0;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;

  // low-power oscillator tick, derived from the 100 mhz clock
  localparam int CLOCK_MHZ      = 100;
  localparam int LPO_TICK_KHZ   = 10;
  localparam int LPO_DIV_CYCLES = (CLOCK_MHZ * 1000) / LPO_TICK_KHZ;

  // lock sequencer states, gray along the unlock path
  typedef enum logic [2:0] {
    LK_LOCKED = 3'b000,
    LK_GOT_1  = 3'b001,
    LK_OPEN   = 3'b011,
    LK_GOT_U  = 3'b010,
    LK_GOT_H  = 3'b110
  } lock_state_t;
endpackage
`default_nettype wire

// File: core/wdog_counter.sv
`timescale 1ns/1ns
`default_nettype none
module wdog_counter
  import wdog_pkg::*;
(
  input  wire logic        clk,        // system clock
  input  wire logic        srst,       // sync reset, high
  input  wire logic        tick,       // low-power oscillator tick
  input  wire logic        run,        // watchdog enabled
  input  wire logic        load,       // copy reload value now
  input  wire logic [23:0] load_value, // reload value
  output logic      [23:0] count_q,    // current count
  output logic             timeout     // one-cycle timeout pulse
);
  // expiry: counter at zero on an oscillator tick
  assign timeout = run & tick & ~load & (count_q == 24'h00_0000);

  // down count on the tick, reload on load or after expiry
  always_ff @(posedge clk)
  begin
    if (srst)
      count_q <= RELOAD_RESET;
    else if (load | timeout)
      count_q <= load_value;
    else if (run & tick)
      count_q <= count_q - 24'h00_0001;
  end
endmodule
`default_nettype wire

// File: core/wdog_top.sv
// Function
// - Timeout with reset enabled, not stopped: pulse system reset, set watchdog cause.
// - Timeout with reset enabled in stop mode: pulse stop recovery instead.
// - Stop-mode timeout with reset enabled sets both watchdog cause and stop cause flags.
// - Three reload bytes stay write protected until unlocked.
// - Unlock code is 55h then aah written to the control address.
// - Unlock code writes leave control bits unchanged.
// - Reload bytes accepted only in order upper, high, low.
// - Any other write mid-sequence relocks and blocks reload writes.
// - Counter loads reload value on each rising enable edge and on each refresh while enabled.
`timescale 1ns/1ns
`default_nettype none
module wdog_top
  import wdog_pkg::*;
#(
  parameter int TICK_DIV = LPO_DIV_CYCLES
)
(
  input  wire logic        CLOCK,         // 100 mhz system clock
  input  wire logic        SRST,          // sync reset, high
  input  wire logic        PSEL,          // apb select
  input  wire logic        PENABLE,       // apb access phase
  input  wire logic        PWRITE,        // apb write
  input  wire logic [7:0]  PADDR,         // apb byte address
  input  wire logic [31:0] PWDATA,        // apb write data
  output logic      [31:0] PRDATA,        // apb read data
  output logic             PREADY,        // apb ready
  output logic             PSLVERR,       // apb error, unmapped
  input  wire logic        STOP_MODE,     // chip in stop mode
  output logic             SYS_RESET,     // system reset pulse
  output logic             STOP_RECOVERY, // stop-mode recovery pulse
  output logic             IRQ            // level interrupt
);
  logic        ctl_enable_q;
  logic        ctl_rst_en_q;
  logic        enable_d1_q;
  logic [7:0]  reload_u_q;
  logic [7:0]  reload_h_q;
  logic [7:0]  reload_l_q;
  logic [1:0]  cause_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic [31:0] prdata_q;
  logic        sys_reset_q;
  logic        stop_rec_q;
  logic        stop_s1_q;
  logic        stop_s2_q;
  logic [31:0] div_q;
  logic        tick;
  logic        wr;
  logic        wr_ctl;
  logic        unlock_byte;
  logic        bad_seq;
  logic        refresh;
  logic        load;
  logic        timeout;
  logic [23:0] count_q;
  lock_state_t lock_q;
  lock_state_t lock_d;

  // address decode shared by write and error paths
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      OFF_CONTROL, OFF_RELOAD_UPPER, OFF_RELOAD_HIGH, OFF_RELOAD_LOW,
      OFF_RESET_CAUSE, OFF_IRQ_STATUS, OFF_IRQ_MASK, OFF_COUNT, OFF_REFRESH:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction

  // zero-wait slave; writes take effect in the access phase
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~is_mapped(PADDR);
  assign PRDATA  = prdata_q;
  assign wr      = PSEL & PENABLE & PWRITE & is_mapped(PADDR);
  assign wr_ctl  = wr & (PADDR == OFF_CONTROL);

  // stop mode comes from the power controller, synchronise it
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
    end
    else
    begin
      stop_s1_q <= STOP_MODE;
      stop_s2_q <= stop_s1_q;
    end
  end

  // divider giving the low-power oscillator tick enable
  always_ff @(posedge CLOCK)
  begin
    if (SRST | tick)
      div_q <= 32'h0000_0000;
    else
      div_q <= div_q + 32'h0000_0001;
  end
  assign tick = (div_q == 32'(TICK_DIV - 1));

  // a control write is an unlock byte when it fits the sequence
  always_comb
  begin
    unlock_byte = 1'b0;
    if (wr_ctl)
    begin
      if (PWDATA[7:0] == UNLOCK_FIRST)
        unlock_byte = 1'b1;
      else if (lock_q == LK_GOT_1 && PWDATA[7:0] == UNLOCK_SECOND)
        unlock_byte = 1'b1;
    end
  end

  // lock sequencer: each write must be the next expected step
  always_comb
  begin
    lock_d  = lock_q;
    bad_seq = 1'b0;
    if (wr)
    begin
      case (lock_q)
        LK_LOCKED:
          lock_d = (wr_ctl && PWDATA[7:0] == UNLOCK_FIRST) ? LK_GOT_1 : LK_LOCKED;
        LK_GOT_1:
          lock_d = (wr_ctl && PWDATA[7:0] == UNLOCK_SECOND) ? LK_OPEN : LK_LOCKED;
        LK_OPEN:
          lock_d = (PADDR == OFF_RELOAD_UPPER) ? LK_GOT_U : LK_LOCKED;
        LK_GOT_U:
          lock_d = (PADDR == OFF_RELOAD_HIGH) ? LK_GOT_H : LK_LOCKED;
        LK_GOT_H:
          lock_d = LK_LOCKED;
        default:
          lock_d = LK_LOCKED;
      endcase
      // a write that breaks an open sequence
      bad_seq = (lock_q != LK_LOCKED) && (lock_d == LK_LOCKED) &&
                !(lock_q == LK_GOT_H && PADDR == OFF_RELOAD_LOW);
      if (wr_ctl && PWDATA[7:0] == UNLOCK_FIRST)
        lock_d = LK_GOT_1;
    end
  end

  // sequencer state
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      lock_q <= LK_LOCKED;
    else
      lock_q <= lock_d;
  end

  // control bits; unlock bytes leave them alone
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      ctl_enable_q <= CONTROL_RESET[CTL_ENABLE_BIT];
      ctl_rst_en_q <= CONTROL_RESET[CTL_RST_EN_BIT];
    end
    else if (wr_ctl && !unlock_byte)
    begin
      ctl_enable_q <= PWDATA[CTL_ENABLE_BIT];
      ctl_rst_en_q <= PWDATA[CTL_RST_EN_BIT];
    end
  end

  // reload bytes, each open only at its own step
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      reload_u_q <= RELOAD_RESET[23:16];
      reload_h_q <= RELOAD_RESET[15:8];
      reload_l_q <= RELOAD_RESET[7:0];
    end
    else if (wr)
    begin
      if (PADDR == OFF_RELOAD_UPPER && lock_q == LK_OPEN)
        reload_u_q <= PWDATA[7:0];
      if (PADDR == OFF_RELOAD_HIGH && lock_q == LK_GOT_U)
        reload_h_q <= PWDATA[7:0];
      if (PADDR == OFF_RELOAD_LOW && lock_q == LK_GOT_H)
        reload_l_q <= PWDATA[7:0];
    end
  end

  // enable edge and refresh both reload the counter
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      enable_d1_q <= 1'b0;
    else
      enable_d1_q <= ctl_enable_q;
  end
  assign refresh = wr & (PADDR == OFF_REFRESH);
  assign load    = (ctl_enable_q & ~enable_d1_q) | (refresh & ctl_enable_q);

  wdog_counter u_counter (
    .clk        (CLOCK),
    .srst       (SRST),
    .tick       (tick),
    .run        (ctl_enable_q),
    .load       (load),
    .load_value ({reload_u_q, reload_h_q, reload_l_q}),
    .count_q    (count_q),
    .timeout    (timeout)
  );

  // timeout action: full reset when running, recovery in stop mode
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      sys_reset_q <= 1'b0;
      stop_rec_q  <= 1'b0;
    end
    else
    begin
      sys_reset_q <= timeout & ctl_rst_en_q & ~stop_s2_q;
      stop_rec_q  <= timeout & ctl_rst_en_q & stop_s2_q;
    end
  end
  assign SYS_RESET     = sys_reset_q;
  assign STOP_RECOVERY = stop_rec_q;

  // reset cause flags, write one to clear, set wins
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      cause_q <= CAUSE_RESET;
    else
    begin
      if (wr && PADDR == OFF_RESET_CAUSE)
        cause_q <= cause_q & ~PWDATA[1:0];
      if (timeout && ctl_rst_en_q)
      begin
        cause_q[CAUSE_WDOG_BIT] <= 1'b1;
        if (stop_s2_q)
          cause_q[CAUSE_STOP_BIT] <= 1'b1;
      end
    end
  end

  // interrupt status write one to clear, set wins; mask written directly
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      irq_stat_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
    end
    else
    begin
      if (wr && PADDR == OFF_IRQ_MASK)
        irq_mask_q <= PWDATA[1:0];
      irq_stat_q <= ((wr && PADDR == OFF_IRQ_STATUS) ? (irq_stat_q & ~PWDATA[1:0]) : irq_stat_q) |
                    {bad_seq, timeout};
    end
  end
  assign IRQ = |(irq_stat_q & irq_mask_q);

  // read data captured in the setup phase
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      prdata_q <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      case (PADDR)
        OFF_CONTROL:      prdata_q <= {30'h0000_0000, ctl_rst_en_q, ctl_enable_q};
        OFF_RELOAD_UPPER: prdata_q <= {24'h00_0000, reload_u_q};
        OFF_RELOAD_HIGH:  prdata_q <= {24'h00_0000, reload_h_q};
        OFF_RELOAD_LOW:   prdata_q <= {24'h00_0000, reload_l_q};
        OFF_RESET_CAUSE:  prdata_q <= {30'h0000_0000, cause_q};
        OFF_IRQ_STATUS:   prdata_q <= {30'h0000_0000, irq_stat_q};
        OFF_IRQ_MASK:     prdata_q <= {30'h0000_0000, irq_mask_q};
        OFF_COUNT:        prdata_q <= {8'h00, count_q};
        default:          prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  sequence s_first_byte;
    wr_ctl && PWDATA[7:0] == UNLOCK_FIRST;
  endsequence
  sequence s_second_byte;
    wr_ctl && PWDATA[7:0] == UNLOCK_SECOND;
  endsequence

  // timeout actions and cause flags
  a_reset_normal: assert property (timeout && ctl_rst_en_q && !stop_s2_q |=>
    SYS_RESET && cause_q[CAUSE_WDOG_BIT])
    else $error("normal timeout gave no system reset");
  a_reset_off: assert property (timeout && !ctl_rst_en_q |=> !SYS_RESET && !STOP_RECOVERY)
    else $error("timeout pulsed with reset disabled");
  a_cause_kept: assert property (!timeout && !(wr && PADDR == OFF_RESET_CAUSE) |=> $stable(cause_q))
    else $error("cause flags changed without event");
  a_stop_recovery: assert property (timeout && ctl_rst_en_q && stop_s2_q |=> STOP_RECOVERY && !SYS_RESET)
    else $error("stop timeout gave no recovery");
  a_stop_cause: assert property (timeout && ctl_rst_en_q && stop_s2_q |=> cause_q == 2'h3)
    else $error("stop timeout cause flags wrong");
  // lock sequencer and reload bytes
  a_reload_locked: assert property (lock_q == LK_LOCKED && wr && PADDR == OFF_RELOAD_UPPER |=>
    $stable(reload_u_q))
    else $error("locked reload byte changed");
  a_high_locked: assert property (lock_q != LK_GOT_U && wr && PADDR == OFF_RELOAD_HIGH |=>
    $stable(reload_h_q))
    else $error("out of step high byte changed");
  a_first_byte: assert property (s_first_byte |=> lock_q == LK_GOT_1)
    else $error("first unlock byte not taken");
  a_unlock_opens: assert property (s_first_byte ##1 (!wr)[*2] ##1 s_second_byte |=> lock_q == LK_OPEN)
    else $error("unlock code did not open");
  a_ctl_kept: assert property (unlock_byte |=> $stable(ctl_enable_q) && $stable(ctl_rst_en_q))
    else $error("unlock byte changed control");
  a_order_upper: assert property (lock_q == LK_OPEN && wr && PADDR == OFF_RELOAD_UPPER |=>
    lock_q == LK_GOT_U && reload_u_q == $past(PWDATA[7:0]))
    else $error("upper byte not taken in order");
  a_order_high: assert property (lock_q == LK_GOT_U && wr && PADDR == OFF_RELOAD_HIGH |=>
    lock_q == LK_GOT_H && reload_h_q == $past(PWDATA[7:0]))
    else $error("high byte not taken in order");
  a_order_low: assert property (lock_q == LK_GOT_H && wr && PADDR == OFF_RELOAD_LOW |=>
    lock_q == LK_LOCKED && reload_l_q == $past(PWDATA[7:0]))
    else $error("low byte not taken in order");
  a_relock_bad: assert property (lock_q == LK_GOT_U && wr && PADDR != OFF_RELOAD_HIGH &&
    !(wr_ctl && PWDATA[7:0] == UNLOCK_FIRST) |=> lock_q == LK_LOCKED)
    else $error("stray write did not relock");
  a_relock_irq: assert property (bad_seq |=> irq_stat_q[IRQ_BADSEQ_BIT])
    else $error("broken sequence not flagged");
  // counter
  a_load_value: assert property (load |=> count_q == {reload_u_q, reload_h_q, reload_l_q})
    else $error("counter not loaded");
  a_count_step: assert property (ctl_enable_q && tick && !load && count_q != 24'h00_0000 |=>
    count_q == $past(count_q) - 24'h00_0001)
    else $error("counter did not step down");
  a_timeout_irq: assert property (timeout |=> irq_stat_q[IRQ_TIMEOUT_BIT])
    else $error("timeout not flagged");
endmodule
`default_nettype wire

// File: verification/wdog_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module wdog_top_tb
  import wdog_pkg::*;
;
  localparam int TDIV = 4;
  logic        CLOCK, SRST, PSEL, PENABLE, PWRITE, STOP_MODE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        PREADY, PSLVERR, SYS_RESET, STOP_RECOVERY, IRQ;
  int          err_count, samples_checked, pulses, seed;
  logic [64:0] acc_q[$];
  logic [1:0]  ev_q[$];
  logic [7:0]  ru, rh, rl;

  wdog_top #(.TICK_DIV(TDIV)) u_dut (.CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .STOP_MODE(STOP_MODE), .SYS_RESET(SYS_RESET), .STOP_RECOVERY(STOP_RECOVERY), .IRQ(IRQ));

  // clock, 10 ns period
  initial
  begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer; the expected answer is noted for the monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e = 32'h0000_0000, input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge CLOCK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    acc_q.push_back({a > OFF_REFRESH, m, e});
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic unlock();
    apb(1'b1, OFF_CONTROL, {24'h0, UNLOCK_FIRST});
    apb(1'b1, OFF_CONTROL, {24'h0, UNLOCK_SECOND});
  endtask

  // interrupt pin, looked at once the last write has settled
  task automatic irq_is(input logic e);
    @(negedge CLOCK);
    chk("irq", {31'h0, e}, {31'h0, IRQ});
  endtask

  // waits, bounded, until n pulses have been seen
  task automatic wait_pulse(input int n);
    for (int i = 0; i < 400 && pulses < n; i++)
      @(posedge CLOCK);
    if (pulses < n)
      chk("pulse_count", n, pulses);
  endtask

  // monitor: each completed access is compared with the oldest note
  always @(posedge CLOCK)
  begin
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1)
    begin
      if (acc_q.size() == 0)
        chk("access_note", 32'h0, 32'h1);
      else
      begin
        logic [64:0] n;
        n = acc_q.pop_front();
        chk("pslverr", {31'h0, n[64]}, {31'h0, PSLVERR});
        if (PWRITE === 1'b0)
          chk("prdata", n[31:0] & n[63:32], PRDATA & n[63:32]);
      end
    end
    if (SYS_RESET === 1'b1 || STOP_RECOVERY === 1'b1)
    begin
      pulses++;
      if (ev_q.size() == 0)
        chk("reset_event", 32'h0, {30'h0, STOP_RECOVERY, SYS_RESET});
      else
        chk("reset_event", {30'h0, ev_q.pop_front()}, {30'h0, STOP_RECOVERY, SYS_RESET});
    end
  end

  // hang guard
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end

  // main sequence
  initial
  begin
    {SRST, PSEL, PENABLE, PWRITE, STOP_MODE} = 5'b10000;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    err_count = 0;
    samples_checked = 0;
    pulses = 0;
    seed = 97;
    repeat (3) @(posedge CLOCK);
    SRST <= 1'b0;
    apb(1'b0, OFF_CONTROL, 32'h0, 32'h0);
    apb(1'b0, OFF_RELOAD_UPPER, 32'h0, {24'h0, RELOAD_RESET[23:16]});
    apb(1'b0, OFF_RELOAD_HIGH, 32'h0, {24'h0, RELOAD_RESET[15:8]});
    apb(1'b0, OFF_RELOAD_LOW, 32'h0, {24'h0, RELOAD_RESET[7:0]});
    apb(1'b0, OFF_RESET_CAUSE, 32'h0, 32'h0);
    apb(1'b0, 8'h24, 32'h0, 32'h0);
    apb(1'b1, 8'h30, 32'h0000_0001);
    ru = 8'($random(seed)) | 8'h01;
    rh = 8'($random(seed)) & 8'hFE;
    rl = 8'($random(seed)) & 8'hFE;
    // locked write is dropped
    apb(1'b1, OFF_RELOAD_UPPER, {24'h0, ru});
    apb(1'b0, OFF_RELOAD_UPPER, 32'h0, {24'h0, RELOAD_RESET[23:16]});
    // unlock then ordered load
    unlock();
    apb(1'b1, OFF_RELOAD_UPPER, {24'h0, ru});
    apb(1'b1, OFF_RELOAD_HIGH, {24'h0, rh});
    apb(1'b1, OFF_RELOAD_LOW, {24'h0, rl});
    apb(1'b0, OFF_CONTROL, 32'h0, 32'h0);
    apb(1'b0, OFF_RELOAD_UPPER, 32'h0, {24'h0, ru});
    apb(1'b0, OFF_RELOAD_HIGH, 32'h0, {24'h0, rh});
    apb(1'b0, OFF_RELOAD_LOW, 32'h0, {24'h0, rl});
    // skipping the upper byte is refused and flagged
    unlock();
    apb(1'b1, OFF_RELOAD_HIGH, 32'h0000_005A);
    apb(1'b0, OFF_RELOAD_HIGH, 32'h0, {24'h0, rh});
    apb(1'b0, OFF_IRQ_STATUS, 32'h0, 32'h0000_0002);
    // a foreign write in mid-sequence relocks
    unlock();
    apb(1'b1, OFF_RELOAD_UPPER, {24'h0, ru ^ 8'h80});
    apb(1'b1, OFF_IRQ_MASK, 32'h0);
    apb(1'b1, OFF_RELOAD_HIGH, 32'h0000_0011);
    apb(1'b0, OFF_RELOAD_UPPER, 32'h0, {24'h0, ru ^ 8'h80});
    apb(1'b0, OFF_RELOAD_HIGH, 32'h0, {24'h0, rh});
    // interrupt masked, unmasked, cleared
    irq_is(1'b0);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_0002);
    irq_is(1'b1);
    apb(1'b1, OFF_IRQ_STATUS, 32'h0000_0002);
    irq_is(1'b0);
    // timeout in normal operation, then in stop mode
    unlock();
    apb(1'b1, OFF_RELOAD_UPPER, 32'h0);
    apb(1'b1, OFF_RELOAD_HIGH, 32'h0);
    apb(1'b1, OFF_RELOAD_LOW, 32'h0000_0007);
    ev_q.push_back(2'b01);
    apb(1'b1, OFF_CONTROL, 32'h0000_0003);
    wait_pulse(1);
    STOP_MODE <= 1'b1;
    ev_q.push_back(2'b10);
    apb(1'b0, OFF_RESET_CAUSE, 32'h0, 32'h0000_0001);
    apb(1'b1, OFF_RESET_CAUSE, 32'h0000_0003);
    wait_pulse(2);
    apb(1'b1, OFF_CONTROL, 32'h0);
    apb(1'b0, OFF_RESET_CAUSE, 32'h0, 32'h0000_0003);
    STOP_MODE <= 1'b0;
    apb(1'b0, OFF_IRQ_STATUS, 32'h0, 32'h0000_0001);
    apb(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
    irq_is(1'b1);
    apb(1'b1, OFF_IRQ_STATUS, 32'h0000_0001);
    irq_is(1'b0);
    // load on enable and on refresh; one tick of slack allowed
    apb(1'b1, OFF_CONTROL, 32'h0000_0001);
    apb(1'b0, OFF_COUNT, 32'h0, 32'h0000_0006, 32'hFFFF_FFFE);
    repeat (12) @(posedge CLOCK);
    apb(1'b1, OFF_REFRESH, 32'h0000_0001);
    apb(1'b0, OFF_COUNT, 32'h0, 32'h0000_0006, 32'hFFFF_FFFE);
    // timeout with reset disabled: status bit only, no pulse
    repeat (40) @(posedge CLOCK);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0, 32'h0000_0001);
    apb(1'b1, OFF_CONTROL, 32'h0);
    repeat (4) @(posedge CLOCK);
    summarize();
  end
endmodule
`default_nettype wire
